// >>> design/ens_hist_mem.sv
// Four-entry event history memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module ens_hist_mem
	import ens_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Write port.
	input wire logic i_we,
	input wire logic [1:0] i_waddr,
	input wire ens_rec_t i_wdata,
	// Read port, data one cycle after the address.
	input wire logic [1:0] i_raddr,
	output ens_rec_t o_rdata
);

	// Registered state and its next value.
	ens_mem_t s_q;
	ens_mem_t n;

	// Write the addressed entry and fetch the read entry.
	always_comb begin
		n = s_q;
		n.rd = s_q.m[i_raddr];
		if (i_we) begin
			n.m[i_waddr] = i_wdata;
		end
	end

	// Empty records read back as number zero.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= n;
		end
	end

	// Read data straight from the register.
	assign o_rdata = s_q.rd;

endmodule
`default_nettype wire

// >>> design/ens_notify.sv
// Event notification, event history and multidrop control with an AHB-Lite slave.
//
// Overview of operation
// - Mask selects which status bits raise events.
// - Setting change sets flag, bumps change counter.
// - Change counter event is never masked.
// - Pending event repeats at retry interval.
// - No pending event: update at max time.
// - Condition must persist debounce time first.
// - Monitoring only when notification control enabled.
// - Acknowledged event stops its retry notifications.
// - Read request zero returns latest event.
// - Acknowledge of latest number clears event status.
// - History read returns n down to n-3.
// - Multidrop only with polling address 1..63.
// - Loop mode off holds 4 mA, no burnout.
// - Loop mode on drives live 4-20 mA.
// - Keep four events; needs publish mode on.
// - Polling address zero leaves multidrop mode.
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`include "ens_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ens_notify
	import ens_pkg::*;
#(
	parameter int unsigned P_TICK_CYC = `ENS_TICK_CYC
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// AHB-Lite slave.
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Status words from the device logic, same clock.
	input wire logic [7:0] i_dev_stat,
	input wire logic [7:0] i_ext_stat,
	input wire logic [7:0] i_diag0,
	input wire logic [7:0] i_diag1,
	input wire logic [15:0] i_grp,
	input wire logic i_cfg_chg,
	// Notification, interrupt and loop outputs.
	output logic o_notify,
	output logic o_irq,
	output logic o_aout_fixed,
	output logic o_burnout_en,
	output logic o_multidrop,
	output logic [5:0] o_poll_addr
);

	// Registered state and its next value.
	ens_st_t s_q;
	ens_st_t n;
	// Address phase accepted this cycle.
	logic acc;
	// Write data phase in progress.
	logic dw;
	// A configuration register is being written.
	logic cfg_wr;
	// Any setting change this cycle.
	logic cfg_p;
	// Event monitoring enabled.
	logic en;
	// Masked status condition.
	logic raw;
	// A new event is recorded this cycle.
	logic newev;
	// Half-second tick.
	logic tick;
	// Device status with the flag, before and after this cycle.
	logic [7:0] devst;
	logic [7:0] devn;
	// History memory ports.
	logic [1:0] mra;
	ens_rec_t mwd;
	ens_rec_t mrd;
	// History slot being captured and its expected number.
	logic [1:0] hk;
	logic [7:0] hexp;

	// Read multiplexer over the register map.
	function automatic logic [31:0] ens_rmux(input ens_st_t t, input logic [7:0] a, input logic [7:0] dv);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			`ENS_A_CTRL: begin
				r[`ENS_CTRL_NOTE] = t.note;
				r[`ENS_CTRL_PUB] = t.pub;
				r[`ENS_CTRL_LOOP] = t.loop;
				r[`ENS_CTRL_ADDR +: 6] = t.paddr;
			end
			`ENS_A_TIM: r[11:0] = {t.dbn, t.mupd, t.rty};
			`ENS_A_MASK0: r = t.mask0;
			`ENS_A_MASK1: r[15:0] = t.mask1;
			`ENS_A_STAT: r[15:0] = {t.lastn, 5'h00, t.rdst == ENS_RD_BUSY, t.paddr != 6'h00, t.pend};
			`ENS_A_CNT: r[15:0] = t.cfgcnt;
			`ENS_A_DEV: r[7:0] = dv;
			`ENS_A_HIST0: r = t.hist[0];
			`ENS_A_HIST1: r = t.hist[1];
			`ENS_A_HIST2: r = t.hist[2];
			`ENS_A_HIST3: r = t.hist[3];
			`ENS_A_ISTAT: r[2:0] = t.istat;
			`ENS_A_IEN: r[2:0] = t.ien;
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// All next-state logic in one pass; clears come before sets so a set wins.
	always_comb begin
		n = s_q;
		n.notify = 1'b0;
		acc = i_hsel & i_htrans[1] & i_hready & (i_hsize == 3'h2) & (i_haddr[31:8] == 24'h000000);
		n.aph = '{sel: acc, wr: i_hwrite, addr: i_haddr[7:0]};
		dw = s_q.aph.sel & s_q.aph.wr;
		en = s_q.note & s_q.pub;
		devst = i_dev_stat;
		devst[`ENS_CFG_BIT] = i_dev_stat[`ENS_CFG_BIT] | s_q.cfgf;
		cfg_wr = 1'b0;
		// Register writes in the data phase.
		if (dw) begin
			case (s_q.aph.addr)
				`ENS_A_CTRL: begin
					cfg_wr = 1'b1;
					n.note = i_hwdata[`ENS_CTRL_NOTE];
					n.pub = i_hwdata[`ENS_CTRL_PUB];
					n.loop = i_hwdata[`ENS_CTRL_LOOP];
					n.paddr = i_hwdata[`ENS_CTRL_ADDR +: 6];
				end
				`ENS_A_TIM: begin
					cfg_wr = 1'b1;
					n.rty = i_hwdata[3:0];
					n.mupd = i_hwdata[7:4];
					n.dbn = i_hwdata[11:8];
				end
				`ENS_A_MASK0: begin
					cfg_wr = 1'b1;
					n.mask0 = i_hwdata;
				end
				`ENS_A_MASK1: begin
					cfg_wr = 1'b1;
					n.mask1 = i_hwdata[15:0];
				end
				`ENS_A_CFGCLR: begin
					if (i_hwdata[`ENS_CFG_BIT]) begin
						n.cfgf = 1'b0;
					end
				end
				`ENS_A_RDREQ: begin
					if (s_q.rdst == ENS_RD_IDLE) begin
						n.rdn = (i_hwdata[7:0] == 8'h00) ? s_q.lastn : i_hwdata[7:0];
						n.rdc = 3'h0;
						n.rdst = ENS_RD_BUSY;
					end
				end
				`ENS_A_ACK: begin
					if (i_hwdata[7:0] == s_q.lastn) begin
						n.pend = 1'b0;
					end
				end
				`ENS_A_ICLR: n.istat = s_q.istat & ~i_hwdata[2:0];
				`ENS_A_IEN: n.ien = i_hwdata[2:0];
				default: n.ien = s_q.ien;
			endcase
		end
		cfg_p = cfg_wr | i_cfg_chg;
		if (cfg_p) begin
			n.cfgf = 1'b1;
			n.cfgcnt = s_q.cfgcnt + 16'h0001;
		end
		// Half-second time base.
		tick = (s_q.tick == 25'(P_TICK_CYC - 1));
		n.tick = tick ? 25'h0000000 : s_q.tick + 25'h0000001;
		raw = (|({devst, i_ext_stat, i_diag0, i_diag1} & s_q.mask0)) | (|(i_grp & s_q.mask1));
		newev = 1'b0;
		if (!en) begin
			n.dbc = 13'h0000;
			n.cond = 1'b0;
		end else if (raw == s_q.cond) begin
			n.dbc = 13'h0000;
		end else if (s_q.dbn == 4'h0 || s_q.dbc >= ens_halfs(s_q.dbn)) begin
			n.cond = raw;
			n.dbc = 13'h0000;
			newev = raw;
		end else if (tick) begin
			n.dbc = s_q.dbc + 13'h0001;
		end
		newev = newev | (cfg_p & en);
		// Time since the last notification, saturating.
		if (!en) begin
			n.since = 13'h0000;
		end else if (tick && s_q.since != 13'h1FFF) begin
			n.since = s_q.since + 13'h0001;
		end
		if (en && s_q.pend && s_q.since >= ens_halfs(s_q.rty)) begin
			n.notify = 1'b1;
			n.since = 13'h0000;
		end
		if (en && !s_q.pend && s_q.since >= ens_halfs(s_q.mupd)) begin
			n.notify = 1'b1;
			n.since = 13'h0000;
		end
		if (newev) begin
			n.lastn = ens_next_num(s_q.lastn);
			n.pend = 1'b1;
			n.notify = 1'b1;
			n.since = 13'h0000;
			n.istat[0] = 1'b1;
		end
		if (n.notify) begin
			n.istat[1] = 1'b1;
		end
		mwd = '{num: n.lastn, info: {devst, i_ext_stat, i_diag0}};
		mra = 2'h0;
		hk = 2'(s_q.rdc - 3'h1);
		hexp = s_q.rdn - {6'h00, hk};
		unique case (s_q.rdst)
			ENS_RD_IDLE: begin
				mra = 2'h0;
			end
			ENS_RD_BUSY: begin
				mra = 2'(s_q.rdn - {5'h00, s_q.rdc});
				if (s_q.rdc != 3'h0) begin
					n.hist[hk] = (mrd.num == hexp) ? mrd : '0;
				end
				if (s_q.rdc == 3'h4) begin
					n.rdst = ENS_RD_IDLE;
					n.istat[2] = 1'b1;
				end else begin
					n.rdc = s_q.rdc + 3'h1;
				end
			end
		endcase
		// Read data reflects writes of this same cycle.
		devn = i_dev_stat;
		devn[`ENS_CFG_BIT] = i_dev_stat[`ENS_CFG_BIT] | n.cfgf;
		n.rdata = (acc && !i_hwrite) ? ens_rmux(n, i_haddr[7:0], devn) : 32'h0000_0000;
	end

	ens_hist_mem u_hist (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_we(newev),
		.i_waddr(n.lastn[1:0]),
		.i_wdata(mwd),
		.i_raddr(mra),
		.o_rdata(mrd)
	);

	// State register with reset values.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_q <= '0;
			s_q.loop <= `ENS_RST_LOOP;
			s_q.rty <= `ENS_RST_RTY;
			s_q.mupd <= `ENS_RST_MUPD;
			s_q.dbn <= `ENS_RST_DBN;
			s_q.rdst <= ENS_RD_IDLE;
		end else begin
			s_q <= n;
		end
	end

	// Bus answers: no wait states, always OKAY.
	assign o_hrdata = s_q.rdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_notify = s_q.notify;
	assign o_irq = |(s_q.istat & s_q.ien);
	assign o_aout_fixed = ~s_q.loop;
	assign o_burnout_en = s_q.loop;
	assign o_multidrop = (s_q.paddr != 6'h00);
	assign o_poll_addr = s_q.paddr;

	// Checks on the block's own behaviour.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_ctrl_wr;
		dw && s_q.aph.addr == `ENS_A_CTRL;
	endsequence
	sequence s_rd_start;
		dw && s_q.aph.addr == `ENS_A_RDREQ && s_q.rdst == ENS_RD_IDLE;
	endsequence
	sequence s_rd_walk;
		(s_q.rdst == ENS_RD_BUSY) [*5] ##1 (s_q.rdst == ENS_RD_IDLE && s_q.istat[2]);
	endsequence

	a_mask_quiet: assert property (
		en && !raw && !cfg_p |=> s_q.lastn == $past(s_q.lastn)) else $error("event without masked cause");
	a_cfg_count: assert property (
		cfg_p |=> s_q.cfgf && s_q.cfgcnt == $past(s_q.cfgcnt) + 16'h0001) else $error("config change not counted");
	a_cfg_event: assert property (
		cfg_p && en |=> s_q.pend && s_q.lastn != $past(s_q.lastn)) else $error("config change gave no event");
	a_retry_fire: assert property (
		en && s_q.pend && s_q.since >= ens_halfs(s_q.rty) |=> o_notify && s_q.since == 13'h0000)
		else $error("retry missed");
	a_update_fire: assert property (
		en && !s_q.pend && s_q.since >= ens_halfs(s_q.mupd) |=> o_notify) else $error("update missed");
	a_debounce_hold: assert property (
		en && s_q.dbn != 4'h0 && s_q.dbc < ens_halfs(s_q.dbn) && !cfg_p |=> s_q.lastn == $past(s_q.lastn))
		else $error("event before debounce time");
	a_off_quiet: assert property (
		!en |=> !o_notify) else $error("notify while monitoring off");
	a_ack_silent: assert property (
		!s_q.pend && s_q.since < ens_halfs(s_q.mupd) && !newev |=> !o_notify) else $error("notify after ack");
	a_read_latest: assert property (
		s_rd_start and (i_hwdata[7:0] == 8'h00) |=> s_q.rdn == $past(s_q.lastn)) else $error("zero read not latest");
	a_ack_clear: assert property (
		dw && s_q.aph.addr == `ENS_A_ACK && i_hwdata[7:0] == s_q.lastn && !newev |=> !s_q.pend)
		else $error("ack did not clear");
	a_hist_walk: assert property (
		s_rd_start |=> s_rd_walk) else $error("history walk length wrong");
	a_drop_enter: assert property (
		s_ctrl_wr and (i_hwdata[13:8] != 6'h00) |=> o_multidrop && o_poll_addr == $past(i_hwdata[13:8]))
		else $error("multidrop not entered");
	a_loop_fixed: assert property (
		s_ctrl_wr and (!i_hwdata[`ENS_CTRL_LOOP]) |=> o_aout_fixed && !o_burnout_en) else $error("loop not fixed");
	a_loop_live: assert property (
		s_ctrl_wr and (i_hwdata[`ENS_CTRL_LOOP]) |=> !o_aout_fixed) else $error("loop not live");
	a_pub_gate: assert property (
		!s_q.pub |=> !o_notify && !$changed(s_q.lastn)) else $error("activity without publish mode");
	a_drop_leave: assert property (
		s_ctrl_wr and (i_hwdata[13:8] == 6'h00) |=> !o_multidrop) else $error("multidrop not left");
	a_num_step: assert property (
		newev |=> s_q.lastn == ens_next_num($past(s_q.lastn))) else $error("event number step wrong");

endmodule
`default_nettype wire

// >>> include/ens_consts.svh
// Constants for the event notification and multidrop block.
`ifndef ENS_CONSTS_SVH
`define ENS_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave.
`define ENS_A_CTRL 8'h00
`define ENS_A_TIM 8'h04
`define ENS_A_MASK0 8'h08
`define ENS_A_MASK1 8'h0C
`define ENS_A_STAT 8'h10
`define ENS_A_CNT 8'h14
`define ENS_A_DEV 8'h18
`define ENS_A_CFGCLR 8'h1C
`define ENS_A_RDREQ 8'h20
`define ENS_A_ACK 8'h24
`define ENS_A_HIST0 8'h28
`define ENS_A_HIST1 8'h2C
`define ENS_A_HIST2 8'h30
`define ENS_A_HIST3 8'h34
`define ENS_A_ISTAT 8'h38
`define ENS_A_ICLR 8'h3C
`define ENS_A_IEN 8'h40

// Control register field positions.
`define ENS_CTRL_NOTE 0
`define ENS_CTRL_PUB 1
`define ENS_CTRL_LOOP 2
`define ENS_CTRL_ADDR 8

// Configuration-changed flag position in the device status word.
`define ENS_CFG_BIT 6

// Reset values of the settings.
`define ENS_RST_RTY 4'h2
`define ENS_RST_MUPD 4'h5
`define ENS_RST_DBN 4'h0
`define ENS_RST_LOOP 1'b1

// Timing: one step of the period table and the clock period.
`define ENS_STEP_MS 500
`define ENS_CLK_NS 25
`define ENS_TICK_CYC (`ENS_STEP_MS * 1000000 / `ENS_CLK_NS)

`endif

// >>> include/ens_pkg.sv
// Types and helper functions of the event notification block.
package ens_pkg;

	// Read walk states, one-hot.
	typedef enum logic [1:0] {
		ENS_RD_IDLE = 2'b01,
		ENS_RD_BUSY = 2'b10
	} ens_rd_t;

	// One history record: event number and a status snapshot.
	typedef struct packed {
		logic [7:0] num;
		logic [23:0] info;
	} ens_rec_t;

	// Captured AHB address phase.
	typedef struct packed {
		logic sel;
		logic wr;
		logic [7:0] addr;
	} ens_aph_t;

	// Whole state of the main module.
	typedef struct packed {
		ens_aph_t aph;
		logic [31:0] rdata;
		logic note;
		logic pub;
		logic loop;
		logic [5:0] paddr;
		logic [3:0] rty;
		logic [3:0] mupd;
		logic [3:0] dbn;
		logic [31:0] mask0;
		logic [15:0] mask1;
		logic cfgf;
		logic [15:0] cfgcnt;
		logic pend;
		logic [7:0] lastn;
		logic [24:0] tick;
		logic [12:0] since;
		logic [12:0] dbc;
		logic cond;
		ens_rd_t rdst;
		logic [2:0] rdc;
		logic [7:0] rdn;
		ens_rec_t [3:0] hist;
		logic [2:0] istat;
		logic [2:0] ien;
		logic notify;
	} ens_st_t;

	// Whole state of the history memory.
	typedef struct packed {
		ens_rec_t [3:0] m;
		ens_rec_t rd;
	} ens_mem_t;

	// Period code to half-second steps; code 0 and 15 fall back to one step.
	function automatic logic [12:0] ens_halfs(input logic [3:0] c);
		logic [12:0] r;
		r = 13'h0001;
		case (c)
			4'h2: r = 13'h0002;
			4'h3: r = 13'h0004;
			4'h4: r = 13'h0008;
			4'h5: r = 13'h0010;
			4'h6: r = 13'h0020;
			4'h7: r = 13'h0040;
			4'h8: r = 13'h0078;
			4'h9: r = 13'h0258;
			4'hA: r = 13'h04B0;
			4'hB: r = 13'h0708;
			4'hC: r = 13'h0E10;
			4'hD: r = 13'h1518;
			4'hE: r = 13'h1C20;
			default: r = 13'h0001;
		endcase
		return r;
	endfunction

	// Next event number; zero is skipped so it can mark an empty record.
	function automatic logic [7:0] ens_next_num(input logic [7:0] x);
		logic [7:0] r;
		r = x + 8'h01;
		if (r == 8'h00) begin
			r = 8'h01;
		end
		return r;
	endfunction

endpackage

// >>> test/ens_host_model.sv
// Host model: an AHB-Lite master that issues single word transfers to the block.
`timescale 1ns/1ps
`default_nettype none
module ens_host_model (
	// Clock and bus answer.
	input wire logic i_clk,
	input wire logic i_hready,
	input wire logic [31:0] i_hrdata,
	// Bus request.
	output logic o_hsel,
	output logic [31:0] o_haddr,
	output logic [1:0] o_htrans,
	output logic o_hwrite,
	output logic [2:0] o_hsize,
	output logic [31:0] o_hwdata
);
	// Read data as it stood at the data-phase edge.
	logic [31:0] cap_q;

	// Idle bus at time zero.
	initial begin
		o_hsel = 1'b0;
		o_haddr = 32'h0;
		o_htrans = 2'h0;
		o_hwrite = 1'b0;
		o_hsize = 3'h2;
		o_hwdata = 32'h0;
	end

	// Capture hrdata on every edge so the data phase value is taken at its own edge.
	always @(posedge i_clk) begin
		cap_q <= i_hrdata;
	end

	// single host
	// One device sits on this line at a unique address, so every transfer targets it alone.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		o_hsel <= 1'b1;
		o_htrans <= 2'h2;
		o_haddr <= {24'h0, a};
		o_hwrite <= w;
		o_hsize <= 3'h2;
		do @(posedge i_clk); while (i_hready !== 1'b1);
		o_hsel <= 1'b0;
		o_htrans <= 2'h0;
		o_haddr <= ~{24'h0, a};
		o_hwdata <= d;
		do @(posedge i_clk); while (i_hready !== 1'b1);
		o_hwdata <= ~d;
		#1;
		q = cap_q;
	endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking testbench of the event notification and multidrop block.
`include "ens_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import ens_pkg::*;
;
	logic clk = 1'b0;
	logic rst;
	logic hsel, hwrite, hready, hresp, cfg_chg;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] dev_stat, ext_stat, diag1;
	logic [15:0] grp;
	logic o_notify, o_irq, o_aout_fixed, o_burnout_en, o_multidrop;
	logic [5:0] o_poll_addr;
	int errors = 0;
	int n_compared = 0;

	// Clock at 40 MHz.
	always #12.5 clk = ~clk;

	ens_notify #(.P_TICK_CYC(8)) dut (.i_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_dev_stat(dev_stat),
		.i_ext_stat(ext_stat), .i_diag0(8'h00), .i_diag1(diag1), .i_grp(grp), .i_cfg_chg(cfg_chg),
		.o_notify(o_notify), .o_irq(o_irq), .o_aout_fixed(o_aout_fixed), .o_burnout_en(o_burnout_en),
		.o_multidrop(o_multidrop), .o_poll_addr(o_poll_addr));

	ens_host_model host (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
		.o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		host.xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		host.xfer(1'b0, a, 32'h0, q);
	endtask

	// Compare, count and report a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	// Latest event number from the status register.
	task automatic latest(output logic [7:0] n);
		logic [31:0] q;
		rd(`ENS_A_STAT, q);
		n = q[15:8];
	endtask

	task automatic pulse_cfg();
		@(posedge clk) cfg_chg <= 1'b1;
		@(posedge clk) cfg_chg <= 1'b0;
		cyc(2);
	endtask

	// Pins packed as {irq, aout_fixed, burnout_en, multidrop, poll_addr}, taken mid-cycle.
	task automatic pins(output logic [31:0] s);
		@(negedge clk);
		s = {22'h0, o_irq, o_aout_fixed, o_burnout_en, o_multidrop, o_poll_addr};
	endtask

	task automatic count_notify(input int k, output int c);
		c = 0;
		repeat (k) begin
			@(negedge clk);
			if (o_notify === 1'b1) c++;
		end
	endtask

	// Start a history walk at number n and wait, bounded, until it is done.
	task automatic walk(input logic [7:0] n);
		logic [31:0] q;
		int k;
		wr(`ENS_A_RDREQ, {24'h0, n});
		k = 0;
		do begin
			rd(`ENS_A_STAT, q);
			k++;
		end while (q[2] !== 1'b0 && k < 20);
		chk({31'h0, q[2]}, 32'h0);
	endtask

	task automatic t_reset();
		logic [31:0] q;
		rd(`ENS_A_CTRL, q);
		chk(q, 32'h0000_0004);
		rd(`ENS_A_TIM, q);
		chk(q, 32'h0000_0052);
		rd(8'h44, q);
		chk(q, 32'h0);
		// Bus answers at once and always with OKAY.
		chk({30'h0, hready, hresp}, 32'h2);
		pins(q);
		chk(q, 32'h0000_0080);
		$display("test reset done");
	endtask

	task automatic t_cfg();
		logic [7:0] n0, n1;
		logic [31:0] q;
		wr(`ENS_A_CTRL, 32'h0000_0007);
		rd(`ENS_A_CNT, q);
		chk(q, 32'h1);
		latest(n0);
		pulse_cfg();
		latest(n1);
		chk({24'h0, n1}, {24'h0, n0 + 8'h01});
		rd(`ENS_A_CNT, q);
		chk(q, 32'h2);
		rd(`ENS_A_DEV, q);
		chk({31'h0, q[6]}, 32'h1);
		wr(`ENS_A_CFGCLR, 32'h0000_0040);
		rd(`ENS_A_DEV, q);
		chk({31'h0, q[6]}, 32'h0);
		$display("test config change done");
	endtask

	task automatic t_mask();
		logic [7:0] n0, n1;
		latest(n0);
		@(posedge clk) diag1 <= 8'h01;
		cyc(4);
		latest(n1);
		chk({24'h0, n1}, {24'h0, n0});
		@(posedge clk) diag1 <= 8'h00;
		// Mask bit 0 is diag1 bit 0 and bit 16 is ext status bit 0.
		wr(`ENS_A_MASK0, 32'h0001_0001);
		latest(n0);
		@(posedge clk) diag1 <= 8'h01;
		cyc(4);
		latest(n1);
		chk({24'h0, n1}, {24'h0, n0 + 8'h01});
		@(posedge clk) diag1 <= 8'h00;
		cyc(2);
		@(posedge clk) ext_stat <= 8'h01;
		cyc(4);
		latest(n1);
		chk({24'h0, n1}, {24'h0, n0 + 8'h02});
		@(posedge clk) ext_stat <= 8'h00;
		wr(`ENS_A_MASK1, 32'h0000_0040);
		latest(n0);
		@(posedge clk) grp <= 16'h0040;
		cyc(4);
		latest(n1);
		chk({24'h0, n1}, {24'h0, n0 + 8'h01});
		@(posedge clk) grp <= 16'h0000;
		$display("test mask done");
	endtask

	task automatic t_notify();
		logic [7:0] n0;
		logic [31:0] q;
		int c;
		latest(n0);
		wr(`ENS_A_ACK, {24'h0, n0 - 8'h01});
		rd(`ENS_A_STAT, q);
		chk({31'h0, q[0]}, 32'h1);
		count_notify(160, c);
		chk({31'h0, c >= 9 && c <= 11}, 32'h1);
		wr(`ENS_A_ACK, {24'h0, n0});
		rd(`ENS_A_STAT, q);
		chk({31'h0, q[0]}, 32'h0);
		count_notify(160, c);
		chk({31'h0, c >= 1 && c <= 2}, 32'h1);
		$display("test notify done");
	endtask

	task automatic t_hist();
		logic [7:0] n0;
		logic [31:0] q;
		latest(n0);
		walk(8'h00);
		for (int i = 0; i < 4; i++) begin
			rd(`ENS_A_HIST0 + 8'(4 * i), q);
			chk({24'h0, q[31:24]}, {24'h0, n0 - 8'(i)});
		end
		walk(n0 - 8'h01);
		rd(`ENS_A_HIST0, q);
		chk({24'h0, q[31:24]}, {24'h0, n0 - 8'h01});
		$display("test history done");
	endtask

	task automatic t_dbn();
		logic [7:0] n0, n1;
		wr(`ENS_A_TIM, 32'h0000_0252);
		latest(n0);
		@(posedge clk) grp <= 16'h0040;
		cyc(3);
		grp <= 16'h0000;
		cyc(40);
		latest(n1);
		chk({24'h0, n1}, {24'h0, n0});
		@(posedge clk) grp <= 16'h0040;
		cyc(60);
		latest(n1);
		chk({24'h0, n1}, {24'h0, n0 + 8'h01});
		@(posedge clk) grp <= 16'h0000;
		$display("test debounce done");
	endtask

	task automatic t_irq();
		logic [31:0] q;
		wr(`ENS_A_IEN, 32'h1);
		wr(`ENS_A_ICLR, 32'h7);
		pins(q);
		chk({31'h0, q[9]}, 32'h0);
		pulse_cfg();
		pins(q);
		chk({31'h0, q[9]}, 32'h1);
		rd(`ENS_A_ISTAT, q);
		chk({31'h0, q[0]}, 32'h1);
		wr(`ENS_A_ICLR, 32'h1);
		pins(q);
		chk({31'h0, q[9]}, 32'h0);
		wr(`ENS_A_IEN, 32'h0);
		pulse_cfg();
		pins(q);
		chk({31'h0, q[9]}, 32'h0);
		$display("test interrupt done");
	endtask

	task automatic t_off();
		logic [7:0] n0, n1;
		logic [31:0] c0, q;
		int c;
		wr(`ENS_A_CTRL, 32'h0000_0004);
		latest(n0);
		rd(`ENS_A_CNT, c0);
		count_notify(200, c);
		chk(32'(c), 32'h0);
		pulse_cfg();
		latest(n1);
		chk({24'h0, n1}, {24'h0, n0});
		rd(`ENS_A_CNT, q);
		chk(q, c0 + 32'h1);
		$display("test monitoring off done");
	endtask

	task automatic t_md();
		logic [31:0] q;
		wr(`ENS_A_CTRL, 32'h0000_0500);
		cyc(2);
		pins(q);
		chk(q, 32'h0000_0145);
		wr(`ENS_A_CTRL, 32'h0000_3F04);
		cyc(2);
		pins(q);
		chk(q, 32'h0000_00FF);
		wr(`ENS_A_CTRL, 32'h0000_0004);
		cyc(2);
		pins(q);
		chk(q, 32'h0000_0080);
		$display("test multidrop done");
	endtask

	// Print the counts and the verdict, then end the run.
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog: the tests need about 900 cycles.
	initial begin
		#150000;
		errors++;
		print_verdict();
	end

	// Main sequence: reset for 20 cycles, then every scenario in turn.
	initial begin
		rst = 1'b1;
		cfg_chg = 1'b0;
		dev_stat = 8'h00;
		diag1 = 8'h00;
		ext_stat = 8'h00;
		grp = 16'h0000;
		cyc(20);
		rst <= 1'b0;
		t_reset();
		t_cfg();
		t_mask();
		t_notify();
		t_hist();
		t_dbn();
		t_irq();
		t_off();
		t_md();
		print_verdict();
	end
endmodule
`default_nettype wire
